// ### flash_host_pkg.sv
// constants for the flash program-and-poll host controller
package flash_host_pkg;
   localparam int CLK_PERIOD_NS = 50;

   // bus timing seen from the host side
   localparam int T_WP_NS = 100;
   localparam int T_WPH_NS = 50;
   localparam int T_ACC_NS = 120;
   localparam int T_OEH_NS = 50;
   localparam int T_RP_NS = 10000;
   localparam int T_READY_NS = 20000;

   // least times round up, never below one cycle
   function automatic int min_cycles(input int ns);
      int c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction

   localparam int SYNC_LAT = 4;
   localparam int WP_CYC = min_cycles(T_WP_NS);
   localparam int WPH_CYC = min_cycles(T_WPH_NS);
   localparam int RD_CYC = min_cycles(T_ACC_NS) + SYNC_LAT;
   localparam int OEH_CYC = min_cycles(T_OEH_NS);
   localparam int RP_CYC = min_cycles(T_RP_NS);
   localparam int READY_CYC = min_cycles(T_READY_NS);
   localparam int CNT_W = 10;

   // command cycles
   localparam logic [10:0] UNLOCK_ADDR_1 = 11'h555;
   localparam logic [10:0] UNLOCK_ADDR_2 = 11'h2aa;
   localparam logic [7:0] UNLOCK_DATA_1 = 8'haa;
   localparam logic [7:0] UNLOCK_DATA_2 = 8'h55;
   localparam logic [7:0] CMD_PROGRAM = 8'ha0;
   localparam logic [7:0] CMD_RESET = 8'hf0;
   localparam logic [1:0] PROG_LAST_STEP = 2'h3;
   localparam logic [1:0] CMD_STEP = 2'h2;

   // status byte positions
   localparam int DATA_POLL_BIT = 7;
   localparam int TOGGLE_BIT_ONE = 6;
   localparam int TIMEOUT_FLAG_BIT = 5;
   localparam int ERASE_WINDOW_BIT = 3;
   localparam int TOGGLE_BIT_TWO = 2;

   // software register map
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_ADDR = 4'h4;
   localparam logic [3:0] REG_DATA = 4'h8;
   localparam logic [3:0] REG_STATUS = 4'hc;
   localparam int CTRL_PROGRAM = 0;
   localparam int CTRL_RESET_CMD = 1;
   localparam int CTRL_HW_RESET = 2;
   localparam int ST_BUSY = 0;
   localparam int ST_DONE = 1;
   localparam int ST_FAIL = 2;
   localparam int ST_TIMEOUT = 3;
   localparam int ST_READY = 4;
   localparam int ST_LAST_LO = 8;
endpackage

// ### flash_pin_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module flash_pin_sync #(
   parameter int W = 9
) (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic [W-1:0] i_d,
   output logic [W-1:0] o_q
);
   logic [W-1:0] ff1_r;
   logic [W-1:0] ff2_r;
   logic [W-1:0] ff3_r;

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         ff1_r <= '0;
         ff2_r <= '0;
         ff3_r <= '0;
         o_q <= '0;
      end else begin
         ff1_r <= i_d;
         ff2_r <= ff1_r;
         ff3_r <= ff2_r;
         // a change counts only once two stages agree
         if (ff2_r == ff3_r) begin
            o_q <= ff3_r;
         end
      end
   end
endmodule
`default_nettype wire

// ### flash_program_host.sv
// host controller: program command, status polling and reset of a parallel flash
//
// Operation
// - three writes: two unlocks, then program code
// - fourth write carries target address and data
// - host reads status twice, compares toggle
// - toggling with timeout set: recheck, then reset
// - interrupted polling restarts from first read
// - after timeout host writes reset command
// - host polls at a valid sector address
`timescale 1ns/1ps
`default_nettype none
module flash_program_host #(
   parameter int ADDR_W = 18
) (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic [3:0] i_reg_addr,
   input wire logic [31:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   output logic [31:0] o_reg_rdata,
   output logic [ADDR_W-1:0] o_flash_addr,
   output logic [7:0] o_flash_dq,
   output logic o_flash_dq_oe_n,
   input wire logic [7:0] i_flash_dq,
   output logic o_flash_ce_n,
   output logic o_flash_we_n,
   output logic o_flash_oe_n,
   output logic o_flash_reset_n,
   input wire logic i_ready_busy
);
   typedef enum logic [3:0] {
      IDLE, WR_SETUP, WR_LOW, WR_HIGH, RD_START, RD_WAIT, RD_GAP, RST_PULSE, RST_WAIT
   } fsm_t;
   typedef enum logic {MODE_PROG, MODE_RST_CMD} mode_t;

   typedef struct packed {
      fsm_t fsm;
      mode_t mode;
      logic [1:0] step;
      logic [flash_host_pkg::CNT_W-1:0] cnt;
      logic [ADDR_W-1:0] addr;
      logic [7:0] wdata;
      logic tog_a;
      logic tog_b;
      logic second;
      logic recheck;
      logic busy;
      logic done;
      logic fail;
      logic tmo;
      logic [7:0] status;
      logic [31:0] rdata;
      logic [ADDR_W-1:0] faddr;
      logic [7:0] fdq;
      logic fdq_oe_n;
      logic ce_n;
      logic we_n;
      logic oe_n;
      logic rst_n;
   } state_t;

   state_t s;
   state_t n;
   logic [8:0] pins_q;

   flash_pin_sync #(.W(9)) u_sync (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_d({i_ready_busy, i_flash_dq}),
      .o_q(pins_q)
   );

   function automatic logic [ADDR_W-1:0] cmd_addr(input mode_t m, input logic [1:0] st,
                                                  input logic [ADDR_W-1:0] tgt);
      if (m == MODE_RST_CMD) begin
         return ADDR_W'(flash_host_pkg::UNLOCK_ADDR_1);
      end
      unique case (st)
         2'h0: return ADDR_W'(flash_host_pkg::UNLOCK_ADDR_1);
         2'h1: return ADDR_W'(flash_host_pkg::UNLOCK_ADDR_2);
         2'h2: return ADDR_W'(flash_host_pkg::UNLOCK_ADDR_1);
         2'h3: return tgt;
      endcase
   endfunction

   function automatic logic [7:0] cmd_data(input mode_t m, input logic [1:0] st,
                                           input logic [7:0] d);
      if (m == MODE_RST_CMD) begin
         return flash_host_pkg::CMD_RESET;
      end
      unique case (st)
         2'h0: return flash_host_pkg::UNLOCK_DATA_1;
         2'h1: return flash_host_pkg::UNLOCK_DATA_2;
         2'h2: return flash_host_pkg::CMD_PROGRAM;
         2'h3: return d;
      endcase
   endfunction

   function automatic logic is_last(input mode_t m, input logic [1:0] st);
      return (m == MODE_RST_CMD) || (st == flash_host_pkg::PROG_LAST_STEP);
   endfunction

   always_comb begin
      n = s;
      n.rdata = '0;
      if (i_reg_rd) begin
         case (i_reg_addr)
            flash_host_pkg::REG_ADDR: n.rdata = 32'(s.addr);
            flash_host_pkg::REG_DATA: n.rdata = 32'(s.wdata);
            flash_host_pkg::REG_STATUS: begin
               n.rdata[flash_host_pkg::ST_BUSY] = s.busy;
               n.rdata[flash_host_pkg::ST_DONE] = s.done;
               n.rdata[flash_host_pkg::ST_FAIL] = s.fail;
               n.rdata[flash_host_pkg::ST_TIMEOUT] = s.tmo;
               n.rdata[flash_host_pkg::ST_READY] = pins_q[8];
               n.rdata[flash_host_pkg::ST_LAST_LO +: 8] = s.status;
            end
            default: n.rdata = '0;
         endcase
      end
      // orders are ignored while an operation runs
      if (i_reg_wr && !s.busy) begin
         case (i_reg_addr)
            flash_host_pkg::REG_ADDR: n.addr = i_reg_wdata[ADDR_W-1:0];
            flash_host_pkg::REG_DATA: n.wdata = i_reg_wdata[7:0];
            flash_host_pkg::REG_CTRL: begin
               if (i_reg_wdata[flash_host_pkg::CTRL_HW_RESET]) begin
                  n.busy = 1'b1;
                  n.done = 1'b0;
                  n.rst_n = 1'b0;
                  n.cnt = flash_host_pkg::CNT_W'(flash_host_pkg::RP_CYC);
                  n.fsm = RST_PULSE;
               end else if (i_reg_wdata[flash_host_pkg::CTRL_PROGRAM] ||
                            i_reg_wdata[flash_host_pkg::CTRL_RESET_CMD]) begin
                  n.busy = 1'b1;
                  n.done = 1'b0;
                  n.fail = 1'b0;
                  n.tmo = 1'b0;
                  n.step = 2'h0;
                  n.mode = i_reg_wdata[flash_host_pkg::CTRL_PROGRAM] ? MODE_PROG : MODE_RST_CMD;
                  n.fsm = WR_SETUP;
               end
            end
            default: ;
         endcase
      end
      unique case (s.fsm)
         IDLE: ;
         WR_SETUP: begin
            // address and data settle one cycle before the strobe falls
            n.ce_n = 1'b0;
            n.faddr = cmd_addr(s.mode, s.step, s.addr);
            n.fdq = cmd_data(s.mode, s.step, s.wdata);
            n.fdq_oe_n = 1'b0;
            n.we_n = 1'b1;
            n.cnt = flash_host_pkg::CNT_W'(flash_host_pkg::WP_CYC);
            n.fsm = WR_LOW;
         end
         WR_LOW: begin
            // strobe falls a cycle after address, chip enable and data, so the latch never races
            n.we_n = 1'b0;
            if (!s.we_n && s.cnt == flash_host_pkg::CNT_W'(1)) begin
               n.we_n = 1'b1;
               n.cnt = flash_host_pkg::CNT_W'(flash_host_pkg::WPH_CYC);
               n.fsm = WR_HIGH;
            end else if (!s.we_n) begin
               n.cnt = s.cnt - flash_host_pkg::CNT_W'(1);
            end
         end
         WR_HIGH: begin
            if (s.cnt == flash_host_pkg::CNT_W'(1)) begin
               n.fdq_oe_n = 1'b1;
               if (!is_last(s.mode, s.step)) begin
                  n.step = s.step + 2'h1;
                  n.fsm = WR_SETUP;
               end else if (s.mode == MODE_PROG) begin
                  // polling stays at the target address
                  n.faddr = s.addr;
                  n.second = 1'b0;
                  n.recheck = 1'b0;
                  n.fsm = RD_START;
               end else begin
                  n.busy = 1'b0;
                  n.done = !s.fail;
                  n.ce_n = 1'b1;
                  n.fsm = IDLE;
               end
            end else begin
               n.cnt = s.cnt - flash_host_pkg::CNT_W'(1);
            end
         end
         RD_START: begin
            n.oe_n = 1'b0;
            n.cnt = flash_host_pkg::CNT_W'(flash_host_pkg::RD_CYC);
            n.fsm = RD_WAIT;
         end
         RD_WAIT: begin
            if (s.cnt == flash_host_pkg::CNT_W'(1)) begin
               // oe must rise between reads, else the toggle bit never moves
               n.oe_n = 1'b1;
               n.status = pins_q[7:0];
               n.cnt = flash_host_pkg::CNT_W'(flash_host_pkg::OEH_CYC);
               n.fsm = RD_GAP;
               if (!s.second) begin
                  n.tog_a = pins_q[flash_host_pkg::TOGGLE_BIT_ONE];
                  n.second = 1'b1;
               end else begin
                  n.tog_b = pins_q[flash_host_pkg::TOGGLE_BIT_ONE];
                  n.second = 1'b0;
                  if (pins_q[flash_host_pkg::TOGGLE_BIT_ONE] == s.tog_a) begin
                     // stable toggle: byte is now array data, check both bits
                     n.busy = 1'b0;
                     n.ce_n = 1'b1;
                     n.fsm = IDLE;
                     if (pins_q[flash_host_pkg::DATA_POLL_BIT] ==
                            s.wdata[flash_host_pkg::DATA_POLL_BIT] &&
                         pins_q[flash_host_pkg::TOGGLE_BIT_ONE] ==
                            s.wdata[flash_host_pkg::TOGGLE_BIT_ONE]) begin
                        n.done = 1'b1;
                     end else begin
                        n.fail = 1'b1;
                     end
                  end else if (s.recheck) begin
                     n.fail = 1'b1;
                     n.mode = MODE_RST_CMD;
                     n.step = 2'h0;
                     n.fsm = WR_SETUP;
                  end else if (pins_q[flash_host_pkg::TIMEOUT_FLAG_BIT]) begin
                     n.tmo = 1'b1;
                     n.recheck = 1'b1;
                  end
               end
            end else begin
               n.cnt = s.cnt - flash_host_pkg::CNT_W'(1);
            end
         end
         RD_GAP: begin
            if (s.cnt == flash_host_pkg::CNT_W'(1)) begin
               n.fsm = RD_START;
            end else begin
               n.cnt = s.cnt - flash_host_pkg::CNT_W'(1);
            end
         end
         RST_PULSE: begin
            if (s.cnt == flash_host_pkg::CNT_W'(1)) begin
               n.rst_n = 1'b1;
               n.cnt = flash_host_pkg::CNT_W'(flash_host_pkg::READY_CYC);
               n.fsm = RST_WAIT;
            end else begin
               n.cnt = s.cnt - flash_host_pkg::CNT_W'(1);
            end
         end
         RST_WAIT: begin
            if (s.cnt == flash_host_pkg::CNT_W'(1)) begin
               n.busy = 1'b0;
               n.done = 1'b1;
               n.fsm = IDLE;
            end else begin
               n.cnt = s.cnt - flash_host_pkg::CNT_W'(1);
            end
         end
         default: n.fsm = IDLE;
      endcase
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         s <= '0;
         s.fsm <= IDLE;
         s.mode <= MODE_PROG;
         s.fdq_oe_n <= 1'b1;
         s.ce_n <= 1'b1;
         s.we_n <= 1'b1;
         s.oe_n <= 1'b1;
         s.rst_n <= 1'b1;
      end else begin
         s <= n;
      end
   end

   assign o_reg_rdata = s.rdata;
   assign o_flash_addr = s.faddr;
   assign o_flash_dq = s.fdq;
   assign o_flash_dq_oe_n = s.fdq_oe_n;
   assign o_flash_ce_n = s.ce_n;
   assign o_flash_we_n = s.we_n;
   assign o_flash_oe_n = s.oe_n;
   assign o_flash_reset_n = s.rst_n;

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);

   property p_write_frame;
      !o_flash_we_n |-> !o_flash_ce_n && o_flash_oe_n && !o_flash_dq_oe_n;
   endproperty
   a_write_frame: assert property (p_write_frame) else $error("write strobe outside frame");

   property p_unlock_first;
      $fell(o_flash_we_n) && s.mode == MODE_PROG && s.step == 2'h0 |->
         o_flash_dq == flash_host_pkg::UNLOCK_DATA_1;
   endproperty
   a_unlock_first: assert property (p_unlock_first) else $error("first unlock wrong");

   property p_cmd_code;
      $fell(o_flash_we_n) && s.mode == MODE_PROG && s.step == flash_host_pkg::CMD_STEP |->
         o_flash_dq == flash_host_pkg::CMD_PROGRAM &&
         o_flash_addr == ADDR_W'(flash_host_pkg::UNLOCK_ADDR_1);
   endproperty
   a_cmd_code: assert property (p_cmd_code) else $error("program code wrong");

   property p_target;
      $fell(o_flash_we_n) && s.mode == MODE_PROG && s.step == flash_host_pkg::PROG_LAST_STEP
         |-> o_flash_addr == s.addr && o_flash_dq == s.wdata ##3 o_flash_dq == s.wdata;
   endproperty
   a_target: assert property (p_target) else $error("target cycle wrong");

   property p_we_width;
      $fell(o_flash_we_n) |-> !o_flash_we_n [*2] ##1 o_flash_we_n;
   endproperty
   a_we_width: assert property (p_we_width) else $error("write pulse width wrong");

   property p_no_contention;
      !o_flash_oe_n |-> o_flash_we_n && o_flash_dq_oe_n && o_flash_addr == s.addr;
   endproperty
   a_no_contention: assert property (p_no_contention) else $error("read with bus driven");

   property p_stable_pair;
      $rose(s.done) && s.mode == MODE_PROG && $past(s.fsm) == RD_WAIT |-> s.tog_a == s.tog_b;
   endproperty
   a_stable_pair: assert property (p_stable_pair) else $error("done without stable toggle");

   property p_fail_reset;
      $rose(s.fail) && s.mode == MODE_RST_CMD |-> s.tmo ##[1:2]
         ($fell(o_flash_we_n) && o_flash_dq == flash_host_pkg::CMD_RESET);
   endproperty
   a_fail_reset: assert property (p_fail_reset) else $error("no reset after failure");

   property p_rd_latency;
      i_reg_rd && i_reg_addr == flash_host_pkg::REG_STATUS |=>
         o_reg_rdata[flash_host_pkg::ST_BUSY] == $past(s.busy);
   endproperty
   a_rd_latency: assert property (p_rd_latency) else $error("status read wrong");

   c_prog_done: cover property ($rose(s.done) && s.mode == MODE_PROG);
   c_prog_fail: cover property ($rose(s.fail) && s.tmo);
   c_hw_reset: cover property ($rose(o_flash_reset_n));
endmodule
`default_nettype wire

// ### flash_dev_model.sv
// behavioural parallel flash: program command, status byte, ready/busy
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model #(
   parameter int ADDR_W = 18,
   parameter int PROG_READS = 5,
   parameter int LOCK_READS = 8,
   parameter int PROT_READS = 3
) (
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [7:0] i_dq,
   input wire logic i_ce_n,
   input wire logic i_we_n,
   input wire logic i_oe_n,
   input wire logic i_reset_n,
   output logic [7:0] o_dq,
   output logic o_dq_en,
   output logic o_rb_low
);
   logic [7:0] mem [int];
   logic [7:0] rd_q = 8'h00;
   logic [7:0] last_d = 8'h00;
   logic [ADDR_W-1:0] a_lat = '0;
   logic [ADDR_W-1:0] tgt = '0;
   logic [1:0] step = 2'h0;
   logic busy = 1'b0;
   logic tmo = 1'b0;
   logic tog = 1'b0;
   logic prot = 1'b0;
   logic lock = 1'b0;
   int reads = 0;
   int n_prog = 0;
   int n_reset = 0;
   int n_hw = 0;
   int rd_bad = 0;

   function automatic logic [1:0] next_step(input logic [1:0] s, input logic [10:0] a,
                                            input logic [7:0] d);
      if (s == 2'h0 && a == 11'h555 && d == 8'haa) return 2'h1;
      if (s == 2'h1 && a == 11'h2aa && d == 8'h55) return 2'h2;
      if (s == 2'h2 && a == 11'h555 && d == 8'ha0) return 2'h3;
      return 2'h0;
   endfunction

   assign o_dq = rd_q;
   assign o_dq_en = !i_ce_n && !i_oe_n && i_we_n;
   // open drain: only ever pulls low, the bench supplies the pull-up
   assign o_rb_low = busy;

   always @(negedge i_we_n) begin
      if (!i_ce_n) a_lat = i_addr;
   end

   always @(posedge i_we_n or negedge i_reset_n) begin
      if (!i_reset_n) begin
         step = 2'h0;
         busy = 1'b0;
         tmo = 1'b0;
         n_hw++;
      end else if (!i_ce_n) begin
         // reset is refused while an algorithm still runs without timeout
         if (i_dq == 8'hf0 && (!busy || tmo)) begin
            step = 2'h0;
            busy = 1'b0;
            tmo = 1'b0;
            n_reset++;
         end else if (!busy && step == 2'h3) begin
            tgt = a_lat;
            last_d = i_dq;
            busy = 1'b1;
            reads = 0;
            step = 2'h0;
            n_prog++;
            prot = a_lat[ADDR_W-1];
            lock = mem.exists(int'(a_lat));
         end else if (!busy) begin
            step = next_step(step, a_lat[10:0], i_dq);
         end
      end
   end

   always @(negedge i_oe_n) begin
      if (!i_ce_n && busy) begin
         if (i_addr !== tgt) rd_bad++;
         tog = ~tog;
         rd_q = {~last_d[7], tog, tmo, 5'h00};
         reads++;
         if (prot && reads >= PROT_READS) begin
            busy = 1'b0;
         end else if (lock && reads >= LOCK_READS) begin
            tmo = 1'b1;
         end else if (!prot && !lock && reads >= PROG_READS) begin
            mem[int'(tgt)] = last_d;
            busy = 1'b0;
         end
      end else if (!i_ce_n) begin
         rd_q = mem.exists(int'(i_addr)) ? mem[int'(i_addr)] : 8'hff;
      end
   end
endmodule
`default_nettype wire

// ### testbench.sv
// self-checking bench for the flash program host controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic [17:0] f_addr;
   logic [7:0] host_dq;
   logic dq_oe_n;
   logic ce_n;
   logic we_n;
   logic oe_n;
   logic reset_n;
   logic [7:0] dev_dq;
   logic dev_en;
   logic rb_low;
   logic [7:0] bus_last = 8'h00;
   logic [31:0] rd_val;
   logic rb_seen = 1'b0;
   int n_fail = 0;
   int check_count = 0;
   // an undriven bus shows the inverse of its last value, never a stale match
   wire logic [7:0] dq_bus = !dq_oe_n ? host_dq : (dev_en ? dev_dq : ~bus_last);
   wire logic ready_pin = !rb_low;

   always #25 clk = ~clk;
   always @(posedge clk) if (!dq_oe_n || dev_en) bus_last <= dq_bus;

   flash_program_host #(.ADDR_W(18)) DUT (.i_ref_clk(clk), .i_rst(rst), .i_reg_addr(reg_addr),
      .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata),
      .o_flash_addr(f_addr), .o_flash_dq(host_dq), .o_flash_dq_oe_n(dq_oe_n),
      .i_flash_dq(dq_bus), .o_flash_ce_n(ce_n), .o_flash_we_n(we_n), .o_flash_oe_n(oe_n),
      .o_flash_reset_n(reset_n), .i_ready_busy(ready_pin));

   flash_dev_model #(.ADDR_W(18)) flash (.i_addr(f_addr), .i_dq(dq_bus), .i_ce_n(ce_n),
      .i_we_n(we_n), .i_oe_n(oe_n), .i_reset_n(reset_n), .o_dq(dev_dq), .o_dq_en(dev_en),
      .o_rb_low(rb_low));

   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one idle edge after each strobe keeps a driver from assigning twice per step
   task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      @(posedge clk);
   endtask

   task automatic reg_read(input logic [3:0] a);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 rd_val = reg_rdata;
      @(posedge clk);
   endtask

   task automatic wait_idle();
      int i;
      i = 0;
      reg_read(flash_host_pkg::REG_STATUS);
      while (rd_val[0] !== 1'b0) begin
         if (rd_val[4] === 1'b0) rb_seen = 1'b1;
         i++;
         if (i > 4000) begin
            n_fail++;
            complete_run();
         end
         reg_read(flash_host_pkg::REG_STATUS);
      end
      // the ready pin passes a synchroniser, so let it settle before judging
      repeat (8) @(posedge clk);
      reg_read(flash_host_pkg::REG_STATUS);
   endtask

   task automatic run_prog(input logic [17:0] a, input logic [7:0] d, input logic [31:0] m,
                           input logic [31:0] exp);
      reg_write(flash_host_pkg::REG_ADDR, {14'h0, a});
      reg_write(flash_host_pkg::REG_DATA, {24'h0, d});
      reg_write(flash_host_pkg::REG_CTRL, 32'h1);
      reg_write(flash_host_pkg::REG_DATA, 32'h77);
      wait_idle();
      chk(rd_val & m, exp);
   endtask

   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      repeat (8) @(posedge clk);
      reg_read(flash_host_pkg::REG_STATUS);
      chk(rd_val, 32'h10);
      reg_read(4'h1);
      chk(rd_val, 32'h0);
      reg_write(flash_host_pkg::REG_ADDR, 32'h2aaaa);
      reg_read(flash_host_pkg::REG_ADDR);
      chk(rd_val, 32'h2aaaa);
      reg_write(flash_host_pkg::REG_DATA, 32'hc3);
      reg_read(flash_host_pkg::REG_DATA);
      chk(rd_val, 32'hc3);
      reg_read(flash_host_pkg::REG_CTRL);
      chk(rd_val, 32'h0);
      run_prog(18'h00123, 8'h5a, 32'hffffffff, 32'h5a12);
      chk({31'h0, rb_seen}, 32'h1);
      reg_read(flash_host_pkg::REG_DATA);
      chk(rd_val, 32'h5a);
      chk({24'h0, flash.mem[32'h123]}, 32'h5a);
      run_prog(18'h00456, 8'ha5, 32'hffffffff, 32'ha512);
      chk(flash.n_prog, 32'h2);
      chk(flash.rd_bad, 32'h0);
      run_prog(18'h20010, 8'h3c, 32'hffffffff, 32'hff14);
      chk({31'h0, flash.mem.exists(32'h20010) != 0}, 32'h0);
      run_prog(18'h00123, 8'h00, 32'h1f, 32'h1c);
      chk(flash.n_reset, 32'h1);
      chk({24'h0, flash.mem[32'h123]}, 32'h5a);
      reg_write(flash_host_pkg::REG_CTRL, 32'h2);
      wait_idle();
      chk(rd_val & 32'hff, 32'h12);
      chk(flash.n_reset, 32'h2);
      reg_write(flash_host_pkg::REG_CTRL, 32'h4);
      wait_idle();
      chk(rd_val & 32'hff, 32'h12);
      chk(flash.n_hw, 32'h1);
      run_prog(18'h00789, 8'h81, 32'hffffffff, 32'h8112);
      complete_run();
   end
endmodule
`default_nettype wire
